// ### hdl/adj_interval_timer.sv
// interval timer for one channel's threshold adjustments
// assumes a one-cycle monitoring tick from the parent's divider
`timescale 1ns/1ns
module adj_interval_timer (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic tick,
	input wire logic run,
	input wire logic [2:0] code,
	// pulses
	output logic dec_due,
	output logic inc_due
);

	logic [11:0] count_r; // monitoring cycles since last restart
	logic [11:0] dec_len; // decrease interval
	logic [11:0] inc_len; // increase interval, twice the decrease one

	assign dec_len = dyn_thr_pkg::IVL_BASE_CYCLES << code;
	assign inc_len = dec_len << 1;

	// count monitoring cycles; a stopped channel restarts from zero
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			count_r <= '0;
		end else if (tick) begin
			if (count_r + 12'h001 >= inc_len) begin
				count_r <= '0;
			end else begin
				count_r <= count_r + 12'h001;
			end
		end
	end

	// due pulses last one system clock
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			dec_due <= 1'b0;
			inc_due <= 1'b0;
		end else begin
			dec_due <= tick && (count_r + 12'h001 == dec_len);
			inc_due <= tick && (count_r + 12'h001 >= inc_len);
		end
	end

endmodule

// ### hdl/dyn_thr_pkg.sv
// constants for the dynamic fan-start-threshold control block
// assumes a 125 MHz system clock and an APB register port with 32-bit data
package dyn_thr_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_OP_REMOTE1 = 10'h033; // remote 1 operating point
	localparam logic [9:0] IDX_OP_LOCAL = 10'h034; // local operating point
	localparam logic [9:0] IDX_OP_REMOTE2 = 10'h035; // remote 2 operating point
	localparam logic [9:0] IDX_ENABLE_CTRL = 10'h036; // dyn_threshold_enable_ctrl
	localparam logic [9:0] IDX_INTERVAL_CTRL = 10'h037; // dyn_threshold_interval_ctrl
	localparam logic [9:0] IDX_CORE_LOW_LIMIT = 10'h046; // core voltage low limit
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h050; // sticky event status
	localparam logic [9:0] IDX_IRQ_MASK = 10'h051; // event mask
	localparam logic [9:0] IDX_CONFIG = 10'h052; // lock bit
	localparam logic [9:0] IDX_LIVE_STATE = 10'h053; // read-only live state

	// decoded register selector
	typedef enum logic [3:0] {
		SEL_NONE, SEL_OP_R1, SEL_OP_LOC, SEL_OP_R2, SEL_EN, SEL_IVL,
		SEL_LIMIT, SEL_STAT, SEL_MASK, SEL_CFG, SEL_LIVE
	} reg_sel_t;

	// reset values
	localparam logic [7:0] OP_POINT_RESET = 8'ha4; // 100 degrees celsius
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] LIMIT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;

	// enable control field positions
	localparam int EN_R2_CODE_MSB = 0;
	localparam int EN_CORE_GUARD = 1;
	localparam int EN_CAP_R1 = 2;
	localparam int EN_CAP_LOC = 3;
	localparam int EN_CAP_R2 = 4;
	localparam int EN_DYN_R1 = 5;
	localparam int EN_DYN_LOC = 6;
	localparam int EN_DYN_R2 = 7;

	// interval control field positions
	localparam int IVL_R1_LO = 0;
	localparam int IVL_LOC_LO = 3;
	localparam int IVL_R2_LO = 6;

	// status and config bit positions
	localparam int STAT_CAPTURE = 0;
	localparam int STAT_CORE_LOW = 1;
	localparam int CFG_LOCK = 0;

	// channel order in per-channel vectors
	localparam int CH_R1 = 0;
	localparam int CH_LOC = 1;
	localparam int CH_R2 = 2;
	localparam int NUM_CH = 3;

	// interval base: code 000 gives 8 cycles to decrease, twice that to increase
	localparam logic [11:0] IVL_BASE_CYCLES = 12'h008;

	// monitoring cycle timing
	localparam int MON_CYCLE_US = 125000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MON_CYCLE_CLKS = MON_CYCLE_US * 1000 / CLK_PERIOD_NS;

endpackage

// ### hdl/dyn_threshold_ctrl.sv
// control registers for dynamic fan-start-threshold adjustment
// assumes APB master on the register side, temperatures and core voltage
// reading supplied by the measurement logic, all inputs synchronous
`timescale 1ns/1ns
module dyn_threshold_ctrl #(
	parameter int MON_CYCLE_CLKS = dyn_thr_pkg::MON_CYCLE_CLKS
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// measurements
	input wire logic [7:0] TEMP_REMOTE1,
	input wire logic [7:0] TEMP_LOCAL,
	input wire logic [7:0] TEMP_REMOTE2,
	input wire logic [7:0] CORE_VOLTAGE_INPUT,
	input wire logic STANDBY_SUPPLY,
	// thermal event pin, active low
	input wire logic THERMAL_EVENT_PIN_N,
	// control outputs
	output logic HOT_PROCESSOR_MONITOR_EN,
	output logic SHUTDOWN_ALLOWED,
	output logic [2:0] DYN_ACTIVE,
	output logic [2:0] THRESHOLD_DEC,
	output logic [2:0] THRESHOLD_INC,
	output logic [7:0] OP_POINT_REMOTE1,
	output logic [7:0] OP_POINT_LOCAL,
	output logic [7:0] OP_POINT_REMOTE2,
	output logic IRQ
);

	////////////////////////////////////////////////////////////////////////
	// register decode
	// map a word index to a register; shared by read and write paths
	function automatic dyn_thr_pkg::reg_sel_t decode(input logic [11:0] addr);
		logic [9:0] idx;
		idx = addr[11:2];
		decode = dyn_thr_pkg::SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			case (idx)
				dyn_thr_pkg::IDX_OP_REMOTE1: decode = dyn_thr_pkg::SEL_OP_R1;
				dyn_thr_pkg::IDX_OP_LOCAL: decode = dyn_thr_pkg::SEL_OP_LOC;
				dyn_thr_pkg::IDX_OP_REMOTE2: decode = dyn_thr_pkg::SEL_OP_R2;
				dyn_thr_pkg::IDX_ENABLE_CTRL: decode = dyn_thr_pkg::SEL_EN;
				dyn_thr_pkg::IDX_INTERVAL_CTRL: decode = dyn_thr_pkg::SEL_IVL;
				dyn_thr_pkg::IDX_CORE_LOW_LIMIT: decode = dyn_thr_pkg::SEL_LIMIT;
				dyn_thr_pkg::IDX_IRQ_STATUS: decode = dyn_thr_pkg::SEL_STAT;
				dyn_thr_pkg::IDX_IRQ_MASK: decode = dyn_thr_pkg::SEL_MASK;
				dyn_thr_pkg::IDX_CONFIG: decode = dyn_thr_pkg::SEL_CFG;
				dyn_thr_pkg::IDX_LIVE_STATE: decode = dyn_thr_pkg::SEL_LIVE;
				default: decode = dyn_thr_pkg::SEL_NONE;
			endcase
		end
	endfunction

	dyn_thr_pkg::reg_sel_t sel; // decoded selector of the current address
	logic setup; // apb setup cycle
	logic commit; // access edge at which a write takes effect
	logic wr_ok; // write with low byte lane enabled
	logic wr_ctrl_ok; // write that the lock permits

	// registers
	logic [7:0] op_r [dyn_thr_pkg::NUM_CH]; // operating points per channel
	logic [7:0] enable_r; // dyn_threshold_enable_ctrl
	logic [7:0] interval_r; // dyn_threshold_interval_ctrl
	logic [7:0] limit_r; // core voltage low limit
	logic [1:0] status_r; // sticky events
	logic [1:0] mask_r; // set bit masks the event
	logic lock_r; // set once, cleared only by reset
	logic core_low; // guard armed, standby supply, voltage under limit
	logic core_low_q; // registered condition
	logic suspend_q; // features suspended

	assign sel = decode(PADDR);
	assign setup = PSEL && !PENABLE;
	assign commit = PSEL && PENABLE && PREADY;
	assign wr_ok = commit && PWRITE && PSTRB[0] && !PSLVERR;
	assign wr_ctrl_ok = wr_ok && !lock_r;

	////////////////////////////////////////////////////////////////////////
	// apb answer

	// answer every access in its first access cycle; data captured at setup
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= setup;
			PSLVERR <= setup && (sel == dyn_thr_pkg::SEL_NONE);
		end
	end

	// read data: narrow registers in the low byte, upper bits zero
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			PRDATA <= 32'h0000_0000;
		end else if (setup && !PWRITE) begin
			case (sel)
				dyn_thr_pkg::SEL_OP_R1: PRDATA <= {24'h000000, op_r[dyn_thr_pkg::CH_R1]};
				dyn_thr_pkg::SEL_OP_LOC: PRDATA <= {24'h000000, op_r[dyn_thr_pkg::CH_LOC]};
				dyn_thr_pkg::SEL_OP_R2: PRDATA <= {24'h000000, op_r[dyn_thr_pkg::CH_R2]};
				dyn_thr_pkg::SEL_EN: PRDATA <= {24'h000000, enable_r};
				dyn_thr_pkg::SEL_IVL: PRDATA <= {24'h000000, interval_r};
				dyn_thr_pkg::SEL_LIMIT: PRDATA <= {24'h000000, limit_r};
				dyn_thr_pkg::SEL_STAT: PRDATA <= {30'h00000000, status_r};
				dyn_thr_pkg::SEL_MASK: PRDATA <= {30'h00000000, mask_r};
				dyn_thr_pkg::SEL_CFG: PRDATA <= {31'h00000000, lock_r};
				dyn_thr_pkg::SEL_LIVE: PRDATA <= {26'h0000000, DYN_ACTIVE, core_low_q, suspend_q, lock_r};
				default: PRDATA <= 32'h0000_0000;
			endcase
		end else if (setup) begin
			PRDATA <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	// enable and interval registers; frozen once locked
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			enable_r <= dyn_thr_pkg::CTRL_RESET;
			interval_r <= dyn_thr_pkg::CTRL_RESET;
		end else if (wr_ctrl_ok) begin
			if (sel == dyn_thr_pkg::SEL_EN) begin
				enable_r <= PWDATA[7:0];
			end
			if (sel == dyn_thr_pkg::SEL_IVL) begin
				interval_r <= PWDATA[7:0];
			end
		end
	end

	// lock is write-once so software cannot undo it
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			lock_r <= 1'b0;
		end else if (wr_ok && sel == dyn_thr_pkg::SEL_CFG && PWDATA[dyn_thr_pkg::CFG_LOCK]) begin
			lock_r <= 1'b1;
		end
	end

	// limit and mask stay writable; they are not part of the locked set
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			limit_r <= dyn_thr_pkg::LIMIT_RESET;
			mask_r <= dyn_thr_pkg::MASK_RESET[1:0];
		end else if (wr_ok) begin
			if (sel == dyn_thr_pkg::SEL_LIMIT) begin
				limit_r <= PWDATA[7:0];
			end
			if (sel == dyn_thr_pkg::SEL_MASK) begin
				mask_r <= PWDATA[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core voltage guard
	assign core_low = enable_r[dyn_thr_pkg::EN_CORE_GUARD] && STANDBY_SUPPLY
		&& (CORE_VOLTAGE_INPUT < limit_r);

	// suspension and gated features follow the condition both ways, so recovery is automatic
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			core_low_q <= 1'b0;
			suspend_q <= 1'b0;
			HOT_PROCESSOR_MONITOR_EN <= 1'b1;
			SHUTDOWN_ALLOWED <= 1'b1;
		end else begin
			core_low_q <= core_low;
			suspend_q <= core_low;
			HOT_PROCESSOR_MONITOR_EN <= !core_low;
			SHUTDOWN_ALLOWED <= !core_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// thermal pin capture
	logic pin_q; // previous pin sample
	logic pin_fall; // asserting edge, active low pin
	logic [2:0] cap_en; // capture enables per channel
	logic [7:0] temp_now [dyn_thr_pkg::NUM_CH]; // live temperatures

	assign pin_fall = pin_q && !THERMAL_EVENT_PIN_N;
	assign cap_en[dyn_thr_pkg::CH_R1] = enable_r[dyn_thr_pkg::EN_CAP_R1];
	assign cap_en[dyn_thr_pkg::CH_LOC] = enable_r[dyn_thr_pkg::EN_CAP_LOC];
	assign cap_en[dyn_thr_pkg::CH_R2] = enable_r[dyn_thr_pkg::EN_CAP_R2];
	assign temp_now[dyn_thr_pkg::CH_R1] = TEMP_REMOTE1;
	assign temp_now[dyn_thr_pkg::CH_LOC] = TEMP_LOCAL;
	assign temp_now[dyn_thr_pkg::CH_R2] = TEMP_REMOTE2;

	// idle high after reset, so a pin held low at release counts as a falling edge
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pin_q <= 1'b1;
		end else begin
			pin_q <= THERMAL_EVENT_PIN_N;
		end
	end

	// operating points; a capture beats a software write in the same cycle
	for (genvar ch = 0; ch < dyn_thr_pkg::NUM_CH; ch++) begin : g_op
		dyn_thr_pkg::reg_sel_t my_sel;
		assign my_sel = (ch == dyn_thr_pkg::CH_R1) ? dyn_thr_pkg::SEL_OP_R1 :
			(ch == dyn_thr_pkg::CH_LOC) ? dyn_thr_pkg::SEL_OP_LOC : dyn_thr_pkg::SEL_OP_R2;
		always_ff @(posedge CLK_SYS) begin
			if (RESET) begin
				op_r[ch] <= dyn_thr_pkg::OP_POINT_RESET;
			end else if (pin_fall && cap_en[ch]) begin
				op_r[ch] <= temp_now[ch];
			end else if (wr_ctrl_ok && sel == my_sel) begin
				op_r[ch] <= PWDATA[7:0];
			end
		end
	end

	// mirror operating points to the adjustment logic
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			OP_POINT_REMOTE1 <= dyn_thr_pkg::OP_POINT_RESET;
			OP_POINT_LOCAL <= dyn_thr_pkg::OP_POINT_RESET;
			OP_POINT_REMOTE2 <= dyn_thr_pkg::OP_POINT_RESET;
		end else begin
			OP_POINT_REMOTE1 <= op_r[dyn_thr_pkg::CH_R1];
			OP_POINT_LOCAL <= op_r[dyn_thr_pkg::CH_LOC];
			OP_POINT_REMOTE2 <= op_r[dyn_thr_pkg::CH_R2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// events and interrupt
	// set wins over a write-one clear in the same cycle; the level interrupt is the
	// alert line when an event is unmasked, one cycle behind the status bits
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			status_r <= 2'h0;
			IRQ <= 1'b0;
		end else begin
			if (wr_ok && sel == dyn_thr_pkg::SEL_STAT) begin
				status_r <= status_r & ~PWDATA[1:0];
			end
			if (pin_fall && (cap_en != 3'h0)) begin
				status_r[dyn_thr_pkg::STAT_CAPTURE] <= 1'b1;
			end
			if (core_low) begin
				status_r[dyn_thr_pkg::STAT_CORE_LOW] <= 1'b1;
			end
			IRQ <= |(status_r & ~mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// monitoring cycle and adjustment timing

	logic [23:0] div_r; // system clocks within one monitoring cycle
	logic mon_tick; // one-cycle monitoring cycle enable
	logic [2:0] dyn_en; // dynamic enables from software
	logic [2:0] code [dyn_thr_pkg::NUM_CH]; // interval codes
	logic [2:0] dec_due; // decrease intervals elapsed
	logic [2:0] inc_due; // increase intervals elapsed

	// divider; a long count, shorten MON_CYCLE_CLKS in simulation
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			div_r <= '0;
			mon_tick <= 1'b0;
		end else if (div_r == 24'(MON_CYCLE_CLKS - 1)) begin
			div_r <= '0;
			mon_tick <= 1'b1;
		end else begin
			div_r <= div_r + 24'h000001;
			mon_tick <= 1'b0;
		end
	end

	assign dyn_en[dyn_thr_pkg::CH_R1] = enable_r[dyn_thr_pkg::EN_DYN_R1];
	assign dyn_en[dyn_thr_pkg::CH_LOC] = enable_r[dyn_thr_pkg::EN_DYN_LOC];
	assign dyn_en[dyn_thr_pkg::CH_R2] = enable_r[dyn_thr_pkg::EN_DYN_R2];
	assign code[dyn_thr_pkg::CH_R1] = interval_r[dyn_thr_pkg::IVL_R1_LO +: 3];
	assign code[dyn_thr_pkg::CH_LOC] = interval_r[dyn_thr_pkg::IVL_LOC_LO +: 3];
	assign code[dyn_thr_pkg::CH_R2] = {enable_r[dyn_thr_pkg::EN_R2_CODE_MSB],
		interval_r[dyn_thr_pkg::IVL_R2_LO +: 2]};

	// one timer per channel, held at zero while disabled or suspended
	for (genvar ch = 0; ch < dyn_thr_pkg::NUM_CH; ch++) begin : g_tmr
		adj_interval_timer u_tmr (
			.clk(CLK_SYS),
			.reset(RESET),
			.tick(mon_tick),
			.run(dyn_en[ch] && !suspend_q),
			.code(code[ch]),
			.dec_due(dec_due[ch]),
			.inc_due(inc_due[ch])
		);
	end

	// a clear enable leaves the threshold alone: no pulses, not active
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			DYN_ACTIVE <= 3'h0;
			THRESHOLD_DEC <= 3'h0;
			THRESHOLD_INC <= 3'h0;
		end else begin
			DYN_ACTIVE <= dyn_en & {3{!core_low}};
			THRESHOLD_DEC <= dec_due & {3{!core_low}};
			THRESHOLD_INC <= inc_due & {3{!core_low}};
		end
	end

endmodule

// ### test/dyn_threshold_ctrl_assertions.sv
// checker for the dynamic threshold control block
// sees only the top module ports; bound to every instance at the foot
`timescale 1ns/1ns
module dyn_threshold_ctrl_assertions #(
	parameter int MON_CYCLE_CLKS = 4
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// environment
	input wire logic STANDBY_SUPPLY,
	input wire logic THERMAL_EVENT_PIN_N,
	// outputs
	input wire logic HOT_PROCESSOR_MONITOR_EN,
	input wire logic SHUTDOWN_ALLOWED,
	input wire logic [2:0] DYN_ACTIVE,
	input wire logic [2:0] THRESHOLD_DEC,
	input wire logic [2:0] THRESHOLD_INC,
	input wire logic [7:0] OP_POINT_LOCAL,
	input wire logic IRQ
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	////////////////////////////////////////////////////////////////
	// register port
	ready_after_setup_a: assert property ((PSEL && !PENABLE) |=> PREADY)
		else $error("no ready in access cycle");
	ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside access");
	error_data_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("error answer malformed");

	////////////////////////////////////////////////////////////////
	// core guard and operating points
	guard_pair_a: assert property (HOT_PROCESSOR_MONITOR_EN == SHUTDOWN_ALLOWED)
		else $error("guard outputs disagree");
	suspend_dyn_a: assert property (!HOT_PROCESSOR_MONITOR_EN |-> DYN_ACTIVE == 3'h0)
		else $error("dynamic control while suspended");
	suspend_cause_a: assert property ($fell(HOT_PROCESSOR_MONITOR_EN) |-> $past(STANDBY_SUPPLY))
		else $error("suspend without standby");
	// the local operating point moves only after a write or a detected falling pin edge
	op_change_cause_a: assert property ($changed(OP_POINT_LOCAL) |-> $past(RESET) ||
		$past(PSEL && PENABLE && PWRITE, 2) || (!$past(THERMAL_EVENT_PIN_N, 2) && $past(THERMAL_EVENT_PIN_N, 3)))
		else $error("operating point changed without cause");
	reset_values_a: assert property ($fell(RESET) |-> OP_POINT_LOCAL == dyn_thr_pkg::OP_POINT_RESET &&
		!IRQ && DYN_ACTIVE == 3'h0)
		else $error("bad reset values");

	////////////////////////////////////////////////////////////////
	// adjustment pulses
	pulse_spacing_a: assert property (THRESHOLD_DEC[0] |=> !THRESHOLD_DEC[0] [*8])
		else $error("decrease pulses too close");
	idle_no_pulse_a: assert property ((DYN_ACTIVE[0] == 1'b0) [*4] |->
		THRESHOLD_DEC[0] == 1'b0 && THRESHOLD_INC[0] == 1'b0)
		else $error("pulse on disabled channel");

	// main scenarios reached
	cover property ($rose(IRQ));
	cover property ($fell(HOT_PROCESSOR_MONITOR_EN));
	cover property (THRESHOLD_INC[2]);
endmodule

bind dyn_threshold_ctrl dyn_threshold_ctrl_assertions #(.MON_CYCLE_CLKS(MON_CYCLE_CLKS)) chk (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STANDBY_SUPPLY(STANDBY_SUPPLY),
	.THERMAL_EVENT_PIN_N(THERMAL_EVENT_PIN_N), .HOT_PROCESSOR_MONITOR_EN(HOT_PROCESSOR_MONITOR_EN),
	.SHUTDOWN_ALLOWED(SHUTDOWN_ALLOWED), .DYN_ACTIVE(DYN_ACTIVE), .THRESHOLD_DEC(THRESHOLD_DEC),
	.THRESHOLD_INC(THRESHOLD_INC), .OP_POINT_LOCAL(OP_POINT_LOCAL), .IRQ(IRQ));

// ### test/dyn_threshold_ctrl_tb.sv
// self-checking bench for the dynamic threshold control block
// assumes the sensor model and the bound checker are compiled alongside
`timescale 1ns/1ns
module dyn_threshold_ctrl_tb;
	localparam int MON = 4; // short monitoring cycle keeps the run brief
	logic clk_sys = 1'b0, reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_v;
	logic pready, pslverr, err_v, irq, hot_en, shut_ok;
	logic [7:0] t1, tl, t2, vcore, op1, opl, op2;
	logic sb, pin_n;
	logic [2:0] dyn, dec, inc;
	int n_errors = 0, num_checks = 0, cyc = 0;

	////////////////////////////////////////////////////////////////
	always #4 clk_sys = ~clk_sys;

	sensor_model sens (.temp_remote1(t1), .temp_local(tl), .temp_remote2(t2), .core_voltage(vcore),
		.standby(sb), .thermal_pin_n(pin_n));

	dyn_threshold_ctrl #(.MON_CYCLE_CLKS(MON)) DUT (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TEMP_REMOTE1(t1), .TEMP_LOCAL(tl),
		.TEMP_REMOTE2(t2), .CORE_VOLTAGE_INPUT(vcore), .STANDBY_SUPPLY(sb), .THERMAL_EVENT_PIN_N(pin_n),
		.HOT_PROCESSOR_MONITOR_EN(hot_en), .SHUTDOWN_ALLOWED(shut_ok), .DYN_ACTIVE(dyn),
		.THRESHOLD_DEC(dec), .THRESHOLD_INC(inc), .OP_POINT_REMOTE1(op1), .OP_POINT_LOCAL(opl),
		.OP_POINT_REMOTE2(op2), .IRQ(irq));

	////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the watchdog
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog: the longest wait is about a thousand cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			complete_run;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// two idle edges so registered outputs behind the write have settled
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd_v, {24'h0, exp}, "register read");
	endtask

	// spacing from a decrease pulse to the following increase pulse
	task automatic gap(input int ch, input int code);
		int t0;
		do @(posedge clk_sys); while (dec[ch] !== 1'b1);
		t0 = cyc;
		do @(posedge clk_sys); while (inc[ch] !== 1'b1);
		chk(cyc - t0, (8 << code) * MON, "adjust interval");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 3; i++) rdchk(10'(dyn_thr_pkg::IDX_OP_REMOTE1 + i), 8'ha4);
		rdchk(dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h00);
		rdchk(dyn_thr_pkg::IDX_INTERVAL_CTRL, 8'h00);
		apb(1'b0, 10'h3ff, 8'h00);
		chk(err_v, 1'b1, "unmapped error");
		$display("test reset done");
		// capture on remote channels only; pin held while readings move
		apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h14);
		sens.set_env(8'h3a, 8'h3b, 8'h3c, 8'hff, 1'b0);
		sens.drive_pin(1'b0);
		repeat (4) @(posedge clk_sys);
		sens.set_env(8'h50, 8'h51, 8'h52, 8'hff, 1'b0);
		repeat (4) @(posedge clk_sys);
		sens.drive_pin(1'b1);
		repeat (2) @(posedge clk_sys);
		rdchk(dyn_thr_pkg::IDX_OP_REMOTE1, 8'h3a);
		rdchk(dyn_thr_pkg::IDX_OP_LOCAL, 8'ha4);
		rdchk(dyn_thr_pkg::IDX_OP_REMOTE2, 8'h3c);
		chk(op2, 8'h3c, "op point port");
		chk({op1, opl, op2}, 24'h3aa43c, "op point ports");
		chk(irq, 1'b1, "capture interrupt");
		rdchk(dyn_thr_pkg::IDX_IRQ_STATUS, 8'h01);
		apb(1'b1, dyn_thr_pkg::IDX_IRQ_MASK, 8'h01);
		chk(irq, 1'b0, "masked interrupt");
		apb(1'b1, dyn_thr_pkg::IDX_IRQ_MASK, 8'h00);
		apb(1'b1, dyn_thr_pkg::IDX_IRQ_STATUS, 8'h01);
		rdchk(dyn_thr_pkg::IDX_IRQ_STATUS, 8'h00);
		chk(irq, 1'b0, "cleared interrupt");
		apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h08);
		sens.drive_pin(1'b0);
		repeat (4) @(posedge clk_sys);
		sens.drive_pin(1'b1);
		repeat (2) @(posedge clk_sys);
		rdchk(dyn_thr_pkg::IDX_OP_LOCAL, 8'h51);
		apb(1'b1, dyn_thr_pkg::IDX_IRQ_STATUS, 8'h01);
		$display("test capture done");
		// remote 1 interval codes
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h00);
			apb(1'b1, dyn_thr_pkg::IDX_INTERVAL_CTRL, 8'(c));
			apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h20);
			chk(dyn, 3'b001, "remote1 active");
			gap(0, c);
		end
		// local code 1, remote 2 code 4 with its top bit in the enable register
		apb(1'b1, dyn_thr_pkg::IDX_INTERVAL_CTRL, 8'h08);
		apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'hc1);
		chk(dyn, 3'b110, "local and remote2 active");
		gap(1, 1);
		gap(2, 4);
		apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h00);
		chk(dyn, 3'b000, "all channels idle");
		$display("test intervals done");
		// core-low guard: suspend only on standby, recover above limit
		apb(1'b1, dyn_thr_pkg::IDX_CORE_LOW_LIMIT, 8'h80);
		apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h22);
		sens.set_env(8'h50, 8'h51, 8'h52, 8'h40, 1'b0);
		repeat (3) @(posedge clk_sys);
		chk(hot_en, 1'b1, "no suspend off standby");
		sens.set_env(8'h50, 8'h51, 8'h52, 8'h40, 1'b1);
		repeat (3) @(posedge clk_sys);
		chk({hot_en, shut_ok, dyn}, 5'b00000, "suspended");
		rdchk(dyn_thr_pkg::IDX_IRQ_STATUS, 8'h02);
		chk(irq, 1'b1, "core low interrupt");
		sens.set_env(8'h50, 8'h51, 8'h52, 8'h90, 1'b1);
		repeat (3) @(posedge clk_sys);
		chk({hot_en, shut_ok, dyn}, 5'b11001, "recovered");
		apb(1'b1, dyn_thr_pkg::IDX_IRQ_STATUS, 8'h02);
		$display("test guard done");
		// lock freezes the control registers
		apb(1'b1, dyn_thr_pkg::IDX_CONFIG, 8'h01);
		apb(1'b1, dyn_thr_pkg::IDX_ENABLE_CTRL, 8'hff);
		apb(1'b1, dyn_thr_pkg::IDX_INTERVAL_CTRL, 8'hff);
		rdchk(dyn_thr_pkg::IDX_ENABLE_CTRL, 8'h22);
		rdchk(dyn_thr_pkg::IDX_INTERVAL_CTRL, 8'h08);
		$display("test lock done");
		complete_run;
	end
endmodule

// ### test/sensor_model.sv
// environment model: readings, supply state and the thermal pin
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ns
module sensor_model (
	// readings
	output logic [7:0] temp_remote1,
	output logic [7:0] temp_local,
	output logic [7:0] temp_remote2,
	output logic [7:0] core_voltage,
	// supply and pin
	output logic standby,
	output logic thermal_pin_n
);
	// pin released high by its pull-up; supply healthy
	initial begin
		temp_remote1 = 8'h20;
		temp_local = 8'h21;
		temp_remote2 = 8'h22;
		core_voltage = 8'hff;
		standby = 1'b0;
		thermal_pin_n = 1'b1;
	end

	// new readings land after the current edge
	task automatic set_env(input logic [7:0] t1, input logic [7:0] tl, input logic [7:0] t2,
		input logic [7:0] v, input logic sb);
		temp_remote1 <= t1;
		temp_local <= tl;
		temp_remote2 <= t2;
		core_voltage <= v;
		standby <= sb;
	endtask

	// caller keeps each level for several cycles so every edge is sampled
	task automatic drive_pin(input logic lvl);
		thermal_pin_n <= lvl;
	endtask
endmodule
